// [rtl/mfc_freq_control.v]
// Fine and coarse frequency control loop with its byte register set
`timescale 1ns/1ps
`include "mfc_regs.vh"

module mfc_freq_control #(
    parameter SHIFT_W = 8,
    parameter FINE_W  = 13,
    parameter FREQ_W  = 16,
    parameter POWER_W = 12
) (
    input  wire                      core_clk,
    input  wire                      arst_n,
    input  wire [9:0]                regAddr,
    input  wire                      regWrEn,
    input  wire [7:0]                regWrData,
    input  wire                      regRdEn,
    output reg  [7:0]                regRdData,
    input  wire                      shiftValid,
    input  wire signed [SHIFT_W-1:0] shiftVal,
    output reg  signed [SHIFT_W-1:0] minShift,
    input  wire                      carrierValid,
    input  wire                      carrierGuard,
    input  wire [POWER_W-1:0]        carrierPower,
    input  wire                      symbolEnd,
    input  wire                      fineValid,
    input  wire signed [FINE_W-1:0]  fineEst,
    input  wire                      coarseValid,
    input  wire signed [12:0]        coarseEst,
    input  wire [7:0]                coarseConf,
    output reg  signed [FREQ_W-1:0]  freqOffset,
    output reg                       freqValid,
    output reg                       loopFrozen
);

    //--------------------------------------------------------------
    // Local constants
    //--------------------------------------------------------------
    localparam ST_INIT   = 3'b001;
    localparam ST_TRACK  = 3'b010;
    localparam ST_FREEZE = 3'b100;
    localparam ACC_W     = POWER_W + 10;
    localparam SC_W      = FINE_W + 9;
    localparam ERR_W     = FINE_W + 1;

    //--------------------------------------------------------------
    // Register file
    //--------------------------------------------------------------
    reg [3:0]  histDepth_r;
    reg [5:0]  loopCtrl_r;
    reg [7:0]  propGain_r;
    reg        blockHold_r;
    reg [1:0]  discardCnt_r;
    reg [12:0] rangeLimit_r;
    reg [7:0]  confMin_r;
    reg [7:0]  ovrLow_r;
    reg [7:0]  fineScale_r;
    reg [7:0]  oorCount_r;
    reg [23:0] powerEst_r;
    reg [12:0] coarse_r;
    reg        ovrLoad_r;

    // Fields of the loop control byte
    wire       avgEn   = loopCtrl_r[`MFC_F_AVG];
    wire       lagSel  = loopCtrl_r[`MFC_F_LAG];
    wire [3:0] intGain = loopCtrl_r[`MFC_F_GAIN_HI:`MFC_F_GAIN_LO];

    // Byte writes; wide fields split low byte first
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            histDepth_r  <= `MFC_R_HIST;
            loopCtrl_r   <= `MFC_R_CTRL;
            propGain_r   <= `MFC_R_PROP;
            blockHold_r  <= `MFC_R_BLOCK;
            discardCnt_r <= `MFC_R_DISCARD;
            rangeLimit_r <= {`MFC_R_LIM_HI, `MFC_R_LIM_LO};
            confMin_r    <= `MFC_R_CONF_MIN;
            ovrLow_r     <= 8'h00;
            fineScale_r  <= `MFC_R_SCALE;
            ovrLoad_r    <= 1'b0;
        end else begin
            ovrLoad_r <= 1'b0;
            if (regWrEn) begin
                case (regAddr)
                    `MFC_A_HIST:     histDepth_r  <= regWrData[3:0];
                    `MFC_A_CTRL:     loopCtrl_r   <= regWrData[5:0];
                    `MFC_A_PROP:     propGain_r   <= regWrData;
                    `MFC_A_BLOCK:    blockHold_r  <= regWrData[0];
                    `MFC_A_DISCARD:  discardCnt_r <= regWrData[1:0];
                    `MFC_A_LIM_LO:   rangeLimit_r[7:0]  <= regWrData;
                    `MFC_A_LIM_HI:   rangeLimit_r[12:8] <= regWrData[4:0];
                    `MFC_A_CONF_MIN: confMin_r    <= regWrData;
                    `MFC_A_OVR_LO:   ovrLow_r     <= regWrData;
                    `MFC_A_OVR_HI:   ovrLoad_r    <= 1'b1;
                    `MFC_A_SCALE:    fineScale_r  <= regWrData;
                    default: ;
                endcase
            end
        end
    end

    // Override high byte kept until the load pulse
    reg [4:0] ovrHigh_r;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ovrHigh_r <= 5'h00;
        end else if (regWrEn && regAddr == `MFC_A_OVR_HI) begin
            ovrHigh_r <= regWrData[4:0];
        end
    end

    // Registered read data, unmapped reads as zero
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `MFC_A_HIST:     regRdData <= {4'h0, histDepth_r};
                `MFC_A_PWR_LO:   regRdData <= powerEst_r[7:0];
                `MFC_A_PWR_MID:  regRdData <= powerEst_r[15:8];
                `MFC_A_PWR_HI:   regRdData <= powerEst_r[23:16];
                `MFC_A_CTRL:     regRdData <= {2'h0, loopCtrl_r};
                `MFC_A_PROP:     regRdData <= propGain_r;
                `MFC_A_BLOCK:    regRdData <= {7'h00, blockHold_r};
                `MFC_A_DISCARD:  regRdData <= {6'h00, discardCnt_r};
                `MFC_A_LIM_LO:   regRdData <= rangeLimit_r[7:0];
                `MFC_A_LIM_HI:   regRdData <= {3'h0, rangeLimit_r[12:8]};
                `MFC_A_CONF_MIN: regRdData <= confMin_r;
                `MFC_A_CRS_LO:   regRdData <= coarse_r[7:0];
                `MFC_A_CRS_HI:   regRdData <= {3'h0, coarse_r[12:8]};
                `MFC_A_SCALE:    regRdData <= fineScale_r;
                `MFC_A_OOR_CNT:  regRdData <= oorCount_r;
                default:         regRdData <= 8'h00;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Window start history
    //--------------------------------------------------------------
    wire signed [SHIFT_W-1:0] histEntry [0:`MFC_HIST_DEPTH];
    genvar gi;

    // Entry 0 is the present shift, older ones move up
    generate
        for (gi = 0; gi <= `MFC_HIST_DEPTH; gi = gi + 1) begin : gHist
            reg  signed [SHIFT_W-1:0] entry_r;
            wire signed [SHIFT_W-1:0] entry_nxt;
            if (gi == 0) begin : gHead
                assign entry_nxt = shiftVal;
            end else begin : gTail
                assign entry_nxt = histEntry[gi-1];
            end
            // One register per entry keeps a single driver each
            always @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    entry_r <= {SHIFT_W{1'b0}};
                end else if (shiftValid) begin
                    entry_r <= entry_nxt;
                end
            end
            assign histEntry[gi] = entry_r;
        end
    endgenerate

    // Minimum over entries 0..depth only
    reg signed [SHIFT_W-1:0] minSearch;
    integer k;
    always @* begin
        minSearch = histEntry[0];
        for (k = 1; k <= `MFC_HIST_DEPTH; k = k + 1) begin
            if (k <= histDepth_r && histEntry[k] < minSearch) begin
                minSearch = histEntry[k];
            end
        end
    end

    // Registered minimum drives the output
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            minShift <= {SHIFT_W{1'b0}};
        end else begin
            minShift <= minSearch;
        end
    end

    //--------------------------------------------------------------
    // Noise and signal power estimate
    //--------------------------------------------------------------
    // Divisors sized to the accumulators so the quotient fits
    localparam [ACC_W-1:0] NOISE_DIV = `MFC_GUARD_CARR;
    localparam [ACC_W-1:0] SIG_DIV   = `MFC_ACTIVE_CARR;

    reg [ACC_W-1:0] noiseAcc_r;
    reg [ACC_W-1:0] sigAcc_r;
    wire [ACC_W-1:0] carrWide = {{(ACC_W-POWER_W){1'b0}}, carrierPower};

    // Per-carrier means; the 12-bit fields keep the low bits
    wire [ACC_W-1:0] noiseMean = noiseAcc_r / NOISE_DIV;
    wire [ACC_W-1:0] sigMean   = sigAcc_r / SIG_DIV;

    // Guard carriers feed noise, the rest feed signal
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            noiseAcc_r <= {ACC_W{1'b0}};
            sigAcc_r   <= {ACC_W{1'b0}};
            powerEst_r <= 24'h000000;
        end else if (symbolEnd) begin
            powerEst_r[23:`MFC_PWR_NOISE_LO] <= noiseMean[POWER_W-1:0];
            powerEst_r[`MFC_PWR_SIG_HI:0]    <= sigMean[POWER_W-1:0];
            noiseAcc_r <= {ACC_W{1'b0}};
            sigAcc_r   <= {ACC_W{1'b0}};
        end else if (carrierValid) begin
            if (carrierGuard) begin
                noiseAcc_r <= noiseAcc_r + carrWide;
            end else begin
                sigAcc_r <= sigAcc_r + carrWide;
            end
        end
    end

    //--------------------------------------------------------------
    // Coarse estimate register
    //--------------------------------------------------------------
    // A refused estimate leaves the last accepted or written value
    // Accepted estimate wins over a same-cycle override
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            coarse_r <= `MFC_R_OVR;
        end else if (coarseValid && coarseConf >= confMin_r) begin
            coarse_r <= coarseEst;
        end else if (ovrLoad_r) begin
            coarse_r <= {ovrHigh_r, ovrLow_r};
        end
    end

    //--------------------------------------------------------------
    // Fine estimate scaling and averaging
    //--------------------------------------------------------------
    wire signed [SC_W-1:0]  scProd =
        fineEst * $signed({1'b0, fineScale_r});
    wire signed [ERR_W-1:0] scaled = scProd[SC_W-1:8];
    reg  signed [ERR_W-1:0] prevScaled_r;
    wire signed [ERR_W:0]   pairSum = scaled + prevScaled_r;
    wire signed [ERR_W-1:0] loopErr =
        avgEn ? pairSum[ERR_W:1] : scaled;

    // Previous scaled estimate for the sliding pair
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prevScaled_r <= {ERR_W{1'b0}};
        end else if (fineValid) begin
            prevScaled_r <= scaled;
        end
    end

    //--------------------------------------------------------------
    // Loop filter terms
    //--------------------------------------------------------------
    wire signed [ERR_W+4:0] intProd =
        loopErr * $signed({1'b0, intGain});
    wire signed [ERR_W+8:0] propProd =
        loopErr * $signed({1'b0, propGain_r});
    // Gains are fractions: integral over 16, proportional over 256
    wire signed [FREQ_W-1:0] intTerm =
        {{(FREQ_W-ERR_W-1){intProd[ERR_W+4]}}, intProd[ERR_W+4:4]};
    wire signed [FREQ_W-1:0] propTerm =
        {{(FREQ_W-ERR_W-1){propProd[ERR_W+8]}}, propProd[ERR_W+8:8]};

    // Integrator wraps at 16 bits; keep gains small
    reg  signed [FREQ_W-1:0] integ_r;
    wire signed [FREQ_W-1:0] integNxt = integ_r + intTerm;
    wire signed [FREQ_W-1:0] freqNxt =
        lagSel ? integNxt + propTerm : integNxt;

    // Distance of fine result from coarse estimate
    wire signed [FREQ_W:0] coarseWide =
        {{(FREQ_W-12){coarse_r[12]}}, coarse_r};
    wire signed [FREQ_W:0] diff =
        {freqNxt[FREQ_W-1], freqNxt} - coarseWide;
    wire [FREQ_W:0] absDiff = diff[FREQ_W] ? -diff : diff;
    wire outOfRange =
        absDiff >= {{(FREQ_W-12){1'b0}}, rangeLimit_r};

    //--------------------------------------------------------------
    // Control state machine
    //--------------------------------------------------------------
    reg [2:0] state_r;
    reg [1:0] skip_r;

    // Startup, tracking and freeze control
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= ST_INIT;
            skip_r     <= 2'h0;
            integ_r    <= {FREQ_W{1'b0}};
            freqOffset <= {FREQ_W{1'b0}};
            freqValid  <= 1'b0;
            oorCount_r <= `MFC_R_OOR_CNT;
            loopFrozen <= 1'b0;
        end else begin
            freqValid  <= 1'b0;
            loopFrozen <= blockHold_r;
            case (state_r)
                ST_INIT: begin
                    if (blockHold_r) begin
                        state_r <= ST_FREEZE;
                    end else if (fineValid) begin
                        // Drop estimates until the count is met, the one that meets it included
                        if (skip_r >= discardCnt_r) begin
                            state_r <= ST_TRACK;
                        end else begin
                            skip_r <= skip_r + 2'h1;
                        end
                    end
                end
                ST_TRACK: begin
                    // Blockage tested first, a frozen loop never updates
                    if (blockHold_r) begin
                        state_r <= ST_FREEZE;
                    end else if (fineValid) begin
                        if (outOfRange) begin
                            // Internal clear, restart discard
                            integ_r    <= {FREQ_W{1'b0}};
                            freqOffset <= {FREQ_W{1'b0}};
                            freqValid  <= 1'b1;
                            skip_r     <= 2'h0;
                            state_r    <= ST_INIT;
                            if (oorCount_r != 8'hff) begin
                                oorCount_r <= oorCount_r + 8'h01;
                            end
                        end else begin
                            integ_r    <= integNxt;
                            freqOffset <= freqNxt;
                            freqValid  <= 1'b1;
                        end
                    end
                end
                ST_FREEZE: begin
                    // Offset held, no updates
                    if (!blockHold_r) begin
                        state_r <= ST_TRACK;
                    end
                end
                default: begin
                    state_r <= ST_INIT;
                end
            endcase
        end
    end

endmodule // mfc_freq_control

// [inc/mfc_regs.vh]
// Register map and field constants of the frequency control block
`ifndef MFC_REGS_VH
`define MFC_REGS_VH

// Byte offsets
`define MFC_A_HIST       10'h117
`define MFC_A_PWR_LO     10'h119
`define MFC_A_PWR_MID    10'h11a
`define MFC_A_PWR_HI     10'h11b
`define MFC_A_CTRL       10'h11c
`define MFC_A_PROP       10'h11d
`define MFC_A_BLOCK      10'h11f
`define MFC_A_DISCARD    10'h120
`define MFC_A_LIM_LO     10'h121
`define MFC_A_LIM_HI     10'h122
`define MFC_A_CONF_MIN   10'h123
`define MFC_A_OVR_LO     10'h124
`define MFC_A_OVR_HI     10'h125
`define MFC_A_CRS_LO     10'h126
`define MFC_A_CRS_HI     10'h127
`define MFC_A_SCALE      10'h128
`define MFC_A_OOR_CNT    10'h12a

// Reset values
`define MFC_R_HIST       4'hf
`define MFC_R_CTRL       6'h1e
`define MFC_R_PROP       8'h04
`define MFC_R_BLOCK      1'h0
`define MFC_R_DISCARD    2'h0
`define MFC_R_LIM_LO     8'h46
`define MFC_R_LIM_HI     5'h00
`define MFC_R_CONF_MIN   8'h90
`define MFC_R_OVR        13'h0000
`define MFC_R_SCALE      8'he0
`define MFC_R_OOR_CNT    8'h00

// Fields of the loop control byte
`define MFC_F_AVG        0
`define MFC_F_LAG        1
`define MFC_F_GAIN_LO    2
`define MFC_F_GAIN_HI    5

// Power estimate layout
`define MFC_PWR_SIG_HI   11
`define MFC_PWR_NOISE_LO 12
`define MFC_GUARD_CARR   24
`define MFC_ACTIVE_CARR  637

// History entries kept besides the present one
`define MFC_HIST_DEPTH   15

`endif

// [bench/mfc_freq_control_properties.sv]
// Port-level assertions of the frequency control block
`timescale 1ns/1ps
`include "mfc_regs.vh"

module mfc_freq_control_properties #(
    parameter SHIFT_W = 8,
    parameter FREQ_W  = 16
) (
    input logic                      core_clk,
    input logic                      arst_n,
    input logic [9:0]                regAddr,
    input logic                      regWrEn,
    input logic [7:0]                regWrData,
    input logic                      regRdEn,
    input logic [7:0]                regRdData,
    input logic                      shiftValid,
    input logic signed [SHIFT_W-1:0] shiftVal,
    input logic signed [SHIFT_W-1:0] minShift,
    input logic                      fineValid,
    input logic signed [FREQ_W-1:0]  freqOffset,
    input logic                      freqValid,
    input logic                      loopFrozen
);
    reg [3:0] depthSh_r;

    // Mirror of the history depth register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            depthSh_r <= `MFC_R_HIST;
        end else if (regWrEn && regAddr == `MFC_A_HIST) begin
            depthSh_r <= regWrData[3:0];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_depth0_push;
        shiftValid && depthSh_r == 4'h0;
    endsequence
    sequence s_quiet2;
        !shiftValid ##1 !shiftValid;
    endsequence

    property p_hist_zero;
        s_depth0_push ##1 s_quiet2 |-> minShift == $past(shiftVal, 2);
    endproperty
    property p_wo_read_zero;
        regRdEn && (regAddr == `MFC_A_OVR_LO || regAddr == `MFC_A_OVR_HI) |=> regRdData == 8'h00;
    endproperty
    property p_rd_hold;
        !$past(regRdEn) |-> $stable(regRdData);
    endproperty
    property p_frozen_follow;
        regWrEn && regAddr == `MFC_A_BLOCK |-> ##2 loopFrozen == $past(regWrData[0], 2);
    endproperty
    property p_frozen_quiet;
        loopFrozen && $past(loopFrozen) |-> !freqValid;
    endproperty
    property p_valid_cause;
        freqValid |-> $past(fineValid);
    endproperty
    property p_offset_hold;
        !$past(fineValid) |-> $stable(freqOffset);
    endproperty
    property p_reset_clear;
        $rose(arst_n) |-> !freqValid && !loopFrozen && freqOffset == 16'sh0000;
    endproperty

    a_hist_zero:     assert property (p_hist_zero)     else $error("min shift not newest");
    a_wo_read_zero:  assert property (p_wo_read_zero)  else $error("override read nonzero");
    a_rd_hold:       assert property (p_rd_hold)       else $error("read data moved");
    a_frozen_follow: assert property (p_frozen_follow) else $error("frozen flag wrong");
    a_frozen_quiet:  assert property (p_frozen_quiet)  else $error("update while frozen");
    a_valid_cause:   assert property (p_valid_cause)   else $error("update without estimate");
    a_offset_hold:   assert property (p_offset_hold)   else $error("offset moved unasked");
    a_reset_clear:   assert property (p_reset_clear)   else $error("outputs not cleared");
endmodule // mfc_freq_control_properties

bind mfc_freq_control mfc_freq_control_properties #(.SHIFT_W(SHIFT_W), .FREQ_W(FREQ_W)) u_props (
    .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .shiftValid(shiftValid), .shiftVal(shiftVal), .minShift(minShift), .fineValid(fineValid),
    .freqOffset(freqOffset), .freqValid(freqValid), .loopFrozen(loopFrozen));

// [bench/tb_top.sv]
// Self-checking bench of the frequency control block
`timescale 1ns/1ps
`include "mfc_regs.vh"

module tb_top;
    logic               core_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [9:0]         regAddr = 10'h000;
    logic               regWrEn = 1'b0;
    logic [7:0]         regWrData = 8'h00;
    logic               regRdEn = 1'b0;
    logic [7:0]         regRdData;
    logic               shiftValid = 1'b0;
    logic signed [7:0]  shiftVal = 8'sh00;
    logic signed [7:0]  minShift;
    logic               carrierValid = 1'b0;
    logic               carrierGuard = 1'b0;
    logic [11:0]        carrierPower = 12'h000;
    logic               symbolEnd = 1'b0;
    logic               fineValid = 1'b0;
    logic signed [12:0] fineEst = 13'sh0000;
    logic               coarseValid = 1'b0;
    logic signed [12:0] coarseEst = 13'sh0000;
    logic [7:0]         coarseConf = 8'h00;
    logic signed [15:0] freqOffset;
    logic               freqValid;
    logic               loopFrozen;
    int                 miscompares = 0;
    int                 nTests = 0;
    logic [9:0] ra [11] = '{`MFC_A_HIST, `MFC_A_CTRL, `MFC_A_PROP, `MFC_A_BLOCK, `MFC_A_DISCARD,
        `MFC_A_LIM_LO, `MFC_A_LIM_HI, `MFC_A_CONF_MIN, `MFC_A_SCALE, `MFC_A_OOR_CNT, `MFC_A_OVR_LO};
    logic [7:0] rv [11] = '{8'h0f, 8'h1e, 8'h04, 8'h00, 8'h00, 8'h46, 8'h00, 8'h90, 8'he0,
        8'h00, 8'h00};
    logic [7:0] rm [11] = '{8'h0f, 8'h3f, 8'hff, 8'h01, 8'h03, 8'hff, 8'h1f, 8'hff, 8'hff,
        8'h00, 8'h00};

    mfc_freq_control dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .shiftValid(shiftValid), .shiftVal(shiftVal), .minShift(minShift),
        .carrierValid(carrierValid), .carrierGuard(carrierGuard),
        .carrierPower(carrierPower), .symbolEnd(symbolEnd), .fineValid(fineValid),
        .fineEst(fineEst), .coarseValid(coarseValid), .coarseEst(coarseEst),
        .coarseConf(coarseConf), .freqOffset(freqOffset), .freqValid(freqValid),
        .loopFrozen(loopFrozen));

    // Free-running 100 MHz clock
    always #5 core_clk = ~core_clk;

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        cyc(1);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        cyc(1);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        cyc(1);
        regAddr = a;
        regRdEn = 1'b1;
        cyc(1);
        regRdEn = 1'b0;
        chk(regRdData, exp);
    endtask
    // One fine estimate, then the loop answer one cycle later
    task automatic fine(input logic signed [12:0] v, input logic ev, input logic [15:0] eo);
        cyc(1);
        fineEst = v;
        fineValid = 1'b1;
        cyc(1);
        fineValid = 1'b0;
        chk(freqValid, ev);
        if (ev) chk(freqOffset, eo);
    endtask
    task automatic crs(input logic signed [12:0] e, input logic [7:0] c);
        cyc(1);
        coarseEst = e;
        coarseConf = c;
        coarseValid = 1'b1;
        cyc(1);
        coarseValid = 1'b0;
    endtask
    task automatic shf(input logic signed [7:0] v, input logic signed [7:0] exp);
        cyc(1);
        shiftVal = v;
        shiftValid = 1'b1;
        cyc(1);
        shiftValid = 1'b0;
        cyc(2);
        chk(minShift, exp);
    endtask
    task automatic pwr(input logic g, input logic [11:0] p, input int n);
        cyc(1);
        carrierGuard = g;
        carrierPower = p;
        carrierValid = 1'b1;
        cyc(n);
        carrierValid = 1'b0;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        cyc(4);
        arst_n = 1'b1;
        for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
        for (int i = 0; i < 11; i++) begin
            wr(ra[i], 8'hff);
            rd(ra[i], rm[i]);
        end
        wr(10'h118, 8'h5a);
        rd(10'h118, 8'h00);
        $display("register test done");
        cyc(1);
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        wr(`MFC_A_SCALE, 8'h80);
        wr(`MFC_A_CTRL, 8'h20);
        wr(`MFC_A_PROP, 8'hff);
        wr(`MFC_A_LIM_LO, 8'h28);
        fine(13'sd64, 1'b0, 16'h0000);
        fine(13'sd64, 1'b1, 16'h0010);
        fine(13'sd64, 1'b1, 16'h0020);
        wr(`MFC_A_DISCARD, 8'h02);
        fine(13'sd64, 1'b1, 16'h0000);
        rd(`MFC_A_OOR_CNT, 8'h01);
        for (int i = 0; i < 3; i++) fine(13'sd64, 1'b0, 16'h0000);
        fine(13'sd64, 1'b1, 16'h0010);
        wr(`MFC_A_BLOCK, 8'h01);
        fine(13'sd64, 1'b0, 16'h0000);
        chk(loopFrozen, 1'b1);
        wr(`MFC_A_BLOCK, 8'h00);
        fine(13'sd64, 1'b1, 16'h0020);
        wr(`MFC_A_LIM_LO, 8'hff);
        wr(`MFC_A_CTRL, 8'h22);
        fine(13'sd64, 1'b1, 16'h004f);
        wr(`MFC_A_CTRL, 8'h21);
        fine(13'sd0, 1'b1, 16'h0038);
        $display("loop test done");
        wr(`MFC_A_OVR_LO, 8'h34);
        wr(`MFC_A_OVR_HI, 8'h12);
        rd(`MFC_A_CRS_LO, 8'h34);
        rd(`MFC_A_CRS_HI, 8'h12);
        crs(13'sh0abc, 8'h8f);
        rd(`MFC_A_CRS_LO, 8'h34);
        crs(13'sh0abc, 8'h90);
        rd(`MFC_A_CRS_LO, 8'hbc);
        rd(`MFC_A_CRS_HI, 8'h0a);
        $display("coarse test done");
        pwr(1'b1, 12'h123, 24);
        pwr(1'b0, 12'h456, 637);
        cyc(1);
        symbolEnd = 1'b1;
        cyc(1);
        symbolEnd = 1'b0;
        rd(`MFC_A_PWR_LO, 8'h56);
        rd(`MFC_A_PWR_MID, 8'h34);
        rd(`MFC_A_PWR_HI, 8'h12);
        $display("power test done");
        wr(`MFC_A_HIST, 8'h00);
        shf(-8'sd2, -8'sd2);
        shf(8'sd7, 8'sd7);
        wr(`MFC_A_HIST, 8'h0f);
        shf(8'sd9, -8'sd2);
        $display("history test done");
        wr(`MFC_A_DISCARD, 8'h00);
        wr(`MFC_A_LIM_LO, 8'h00);
        for (int i = 0; i < 260; i++) begin
            fine(13'sd64, 1'b1, 16'h0000);
            fine(13'sd64, 1'b0, 16'h0000);
        end
        rd(`MFC_A_OOR_CNT, 8'hff);
        $display("saturation test done");
        final_report();
    end

    // Watchdog against a hung handshake
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule // tb_top
